/* File: seic_pkg.sv */
// Package: constants and types for the serial I/O enable control block
// Functional notes
// R1: Enabled port drivers output the port latch; port pins are readable back.
// R2: Serial register is 4 bits, shift or counter by mode, exchangeable with accumulator.
// R3: Swap instruction copies carry into the clock-gate latch.
// R4: Counter mode: sync clock equals latch; shift mode: clock per cycle, low if latch 0.
// R5: Feature-select is a 4-bit register written by load-feature-select, one feature per bit.
// R6: Counter mode decrements serial register on each falling edge of serial input.
// R7: External pulse source keeps each pulse at least two instruction cycles wide.
// R8: Shift mode shifts left once per instruction cycle, serial input into bit 0.
// R9: Feature-select bit 1 has no effect.
// R10: Port-drive bit enables port drivers; clear leaves pins high-impedance inputs.
// R11: Counter mode: serial output follows the serial-output bit.
// R12: Shift mode with serial-output bit set: serial output is register MSB each cycle.
// R13: Shift mode with serial-output bit clear: serial output stays 0, shifting continues.
// R14: Init needs reset pin low three instruction cycles; source must hold it that long.
// R15: Init clears program counter, accumulator, pointer, carry, feature-select, aux latch.
// R16: After init the sync clock pulses once per instruction cycle.
// R17: Halt stops internal clocking, keeps state, forces oscillator output to 1.
// R18: Halted device wakes only through reset.
// R19: Crystal option: instruction cycle is oscillator frequency divided by 8.
// R20: RC option: instruction cycle is oscillation divided by 4; oscillator output unused.
// R21: Halted under RC option, oscillator stops with its input pin high.
// R22: Port latch is 8 bits, loaded from RAM with accumulator or from ROM data.
// R23: Counter decrement from zero wraps to fifteen.
package seic_pkg;

	localparam int          SEIC_CLK_NS     = 40;
	localparam int          SEIC_DIV_XTAL   = 8;
	localparam int          SEIC_DIV_RC     = 4;
	localparam int          SEIC_INIT_CYC   = 3;
	localparam int          SEIC_FS_CNT     = 0;
	localparam int          SEIC_FS_UNUSED  = 1;
	localparam int          SEIC_FS_PORT    = 2;
	localparam int          SEIC_FS_SO      = 3;
	localparam logic [3:0]  SEIC_FSEL_RST   = 4'h0;
	localparam logic [3:0]  SEIC_SSC_RST    = 4'h0;
	localparam logic        SEIC_LATCH_RST  = 1'b1;
	localparam logic [7:0]  SEIC_PORT_RST   = 8'h00;
	localparam logic [1:0]  SEIC_INIT_MAX   = 2'h3;

	typedef enum logic [2:0]
	{
		SEIC_CMD_NOP  = 3'h0,
		SEIC_CMD_LOAD_FSEL = 3'h1,
		SEIC_CMD_SWAP = 3'h2,
		SEIC_CMD_HALT = 3'h3,
		SEIC_CMD_CAMQ = 3'h4,
		SEIC_CMD_LQID = 3'h5
	} seic_cmd_e;

	typedef enum logic [1:0]
	{
		SEIC_ST_INIT = 2'h0,
		SEIC_ST_RUN  = 2'h1,
		SEIC_ST_HALT = 2'h3
	} seic_state_e;

endpackage

/* File: seic_cyc_if.sv */
// Interface carrying the instruction cycle timing between the cycle generator and the top
`timescale 1ns/1ps
interface seic_cyc_if;
	logic tick;
	logic phase;
	logic halt;
	logic rc_mode;

	modport gen
	(
		output tick,
		output phase,
		output rc_mode,
		input  halt
	);

	modport use_side
	(
		input  tick,
		input  phase,
		input  rc_mode,
		output halt
	);
endinterface

/* File: seic_cycle_gen.sv */
// Instruction cycle generator: samples the oscillator pin and divides it by the option ratio
`timescale 1ns/1ps
module seic_cycle_gen
	import seic_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  resetn,
	// Oscillator pins
	input  wire logic  osc_in_pin,
	input  wire logic  rc_option_pin,
	output logic       osc_out_pin,
	output logic       osc_out_oe,
	output logic       osc_in_o,
	output logic       osc_in_oe,
	// Cycle carrier
	seic_cyc_if.gen    cyc
);
	typedef struct packed {
		logic [1:0] osc_s;
		logic       osc_prev;
		logic [1:0] rc_s;
		logic [2:0] cnt;
		logic       tick;
		logic       phase;
		logic       oout;
		logic       stop_hi;
	} seic_gen_s;

	seic_gen_s st_reg;
	seic_gen_s st_next;
	logic [2:0] last;

	always_comb
	begin
		st_next = st_reg;
		st_next.osc_s = {st_reg.osc_s[0], osc_in_pin};
		st_next.rc_s = {st_reg.rc_s[0], rc_option_pin};
		st_next.osc_prev = st_reg.osc_s[1];
		st_next.tick = 1'b0;
		// Divide by 4 for RC, by 8 for crystal [R19] [R20]
		last = st_reg.rc_s[1] ? 3'(SEIC_DIV_RC - 1) : 3'(SEIC_DIV_XTAL - 1);
		if (st_reg.osc_s[1] && !st_reg.osc_prev)
		begin
			if (st_reg.cnt >= last)
			begin
				st_next.cnt = 3'h0;
				st_next.tick = 1'b1;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + 3'h1;
			end
		end
		// First half of the cycle carries the sync clock high
		// High for counts 1 to half the divider, a clean half cycle
		st_next.phase = (st_next.cnt != 3'h0) && (st_next.cnt <= ((last >> 1) + 3'h1));
		// Halt forces the output high [R17]
		st_next.oout = cyc.halt ? 1'b1 : !st_reg.osc_s[1];
		// RC oscillator parked high while halted [R21]
		st_next.stop_hi = cyc.halt && st_reg.rc_s[1];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign cyc.tick    = st_reg.tick;
	assign cyc.phase   = st_reg.phase;
	assign cyc.rc_mode = st_reg.rc_s[1];
	assign osc_out_pin = st_reg.oout;
	assign osc_out_oe  = !st_reg.rc_s[1]; // Output left unconnected in RC option [R20]
	assign osc_in_o    = 1'b1;
	assign osc_in_oe   = st_reg.stop_hi;
endmodule

/* File: seic_top.sv */
// Top of the serial I/O and feature-enable control block
`timescale 1ns/1ps
module seic_top
	import seic_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Device reset pin
	input  wire logic        init_pin_n,
	// Oscillator pins
	input  wire logic        osc_in_pin,
	input  wire logic        rc_option_pin,
	output logic             osc_out_pin,
	output logic             osc_out_oe,
	output logic             osc_in_o,
	output logic             osc_in_oe,
	// Instruction port from the core
	input  wire logic        cmd_valid,
	input  wire seic_pkg::seic_cmd_e cmd,
	input  wire logic [3:0]  cmd_acc,
	input  wire logic [3:0]  cmd_mem,
	input  wire logic        cmd_carry,
	input  wire logic [7:0]  cmd_rom,
	output logic             cmd_ready,
	// Results to the core
	output logic [3:0]       ssc_rd_data,
	output logic [7:0]       port_rd_data,
	output logic             init_active,
	output logic             halted,
	// Serial pins
	input  wire logic        serial_in_pin,
	output logic             sync_clock_out,
	output logic             serial_out_pin,
	// Wide port pins
	input  wire logic [7:0]  port_in,
	output logic [7:0]       port_out,
	output logic [7:0]       port_oe
);
	import seic_pkg::*;

	typedef struct packed {
		seic_state_e state;
		logic [3:0]  fsel;
		logic [3:0]  ssc;
		logic        latch;
		logic [7:0]  port_latch;
		logic [3:0]  ssc_rd;
		logic [1:0]  si_s;
		logic        si_prev;
		logic [1:0]  rst_s;
		logic [1:0]  init_cnt;
		logic [7:0]  port_s1;
		logic [7:0]  port_s2;
		logic [7:0]  port_rd;
		logic        sync_clk;
		logic        so;
		logic        drive;
	} seic_top_s;

	seic_top_s st_reg;
	seic_top_s st_next;

	seic_cyc_if cyc ();

	logic run_tick;
	logic si_fall;
	logic take;

	seic_cycle_gen u_gen
	(
		.clk           (clk),
		.resetn        (resetn),
		.osc_in_pin    (osc_in_pin),
		.rc_option_pin (rc_option_pin),
		.osc_out_pin   (osc_out_pin),
		.osc_out_oe    (osc_out_oe),
		.osc_in_o      (osc_in_o),
		.osc_in_oe     (osc_in_oe),
		.cyc           (cyc)
	);

	// Serial output select by counter-mode and serial-output bits
	function automatic logic seic_so_sel
	(
		input logic [3:0] fsel,
		input logic [3:0] ssc
	);
		logic r;
		r = 1'b0;
		if (fsel[SEIC_FS_CNT])
			r = fsel[SEIC_FS_SO]; // [R11]
		else if (fsel[SEIC_FS_SO])
			r = ssc[3]; // [R12]
		else
			r = 1'b0; // [R13]
		return r;
	endfunction

	// Sync clock select by mode, latch and cycle phase
	function automatic logic seic_sync_sel
	(
		input logic [3:0] fsel,
		input logic       latch,
		input logic       phase
	);
		logic r;
		r = 1'b0;
		if (fsel[SEIC_FS_CNT])
			r = latch; // [R4]
		else
			r = latch && phase; // [R4] [R16]
		return r;
	endfunction

	assign cyc.halt = (st_reg.state == SEIC_ST_HALT);
	// Halt freezes the serial shift paced by the instruction cycle; init_cnt still counts ticks [R17]
	assign run_tick = cyc.tick && (st_reg.state == SEIC_ST_RUN);
	assign si_fall = st_reg.si_prev && !st_reg.si_s[1];
	assign cmd_ready = (st_reg.state == SEIC_ST_RUN);
	assign take = cmd_valid && cmd_ready;

	always_comb
	begin
		st_next = st_reg;

		// Pin synchronisers
		st_next.si_s = {st_reg.si_s[0], serial_in_pin};
		st_next.rst_s = {st_reg.rst_s[0], init_pin_n};
		st_next.port_s1 = port_in;
		st_next.port_s2 = st_reg.port_s1;

		// Edge history only advances while running, so a halt loses no edge state
		if (st_reg.state == SEIC_ST_RUN)
			st_next.si_prev = st_reg.si_s[1];

		// Port readback
		st_next.port_rd = st_reg.port_s2; // [R1]

		// Serial register: counter or shifter by feature bit 0
		if (st_reg.state == SEIC_ST_RUN)
		begin
			if (st_reg.fsel[SEIC_FS_CNT])
			begin
				// Pulses narrower than two cycles may be missed [R7]
				if (si_fall)
					st_next.ssc = st_reg.ssc - 4'h1; // [R6] [R23]
			end
			else if (run_tick)
			begin
				st_next.ssc = {st_reg.ssc[2:0], st_reg.si_s[1]}; // [R8] [R2]
			end
		end

		// Instructions
		if (take)
		begin
			unique case (cmd)
				SEIC_CMD_NOP:
				begin
					st_next.fsel = st_reg.fsel;
				end
				SEIC_CMD_LOAD_FSEL:
				begin
					st_next.fsel = cmd_acc; // [R5] [R9]
				end
				SEIC_CMD_SWAP:
				begin
					// Exchange beats a same-cycle shift or count
					st_next.ssc_rd = st_reg.ssc; // [R2]
					st_next.ssc = cmd_acc; // [R2]
					st_next.latch = cmd_carry; // [R3]
				end
				SEIC_CMD_HALT:
				begin
					st_next.state = SEIC_ST_HALT; // [R17]
				end
				SEIC_CMD_CAMQ:
				begin
					st_next.port_latch = {cmd_acc, cmd_mem}; // [R22]
				end
				SEIC_CMD_LQID:
				begin
					st_next.port_latch = cmd_rom; // [R22]
				end
				default:
				begin
					st_next.fsel = st_reg.fsel;
				end
			endcase
		end

		// Reset pin must stay low for three instruction cycles [R14]
		if (st_reg.rst_s[1])
		begin
			st_next.init_cnt = 2'h0;
			if (st_reg.state == SEIC_ST_INIT)
				st_next.state = SEIC_ST_RUN;
		end
		else if (cyc.tick && st_reg.init_cnt != SEIC_INIT_MAX)
		begin
			st_next.init_cnt = st_reg.init_cnt + 2'h1;
		end

		// Only the reset sequence leaves halt [R18]
		if (st_reg.init_cnt == 2'(SEIC_INIT_CYC) && !st_reg.rst_s[1])
		begin
			st_next.state = SEIC_ST_INIT; // [R14] [R18]
			st_next.fsel = SEIC_FSEL_RST; // [R15]
			st_next.ssc = SEIC_SSC_RST;
			st_next.latch = SEIC_LATCH_RST; // [R16]
			st_next.port_latch = SEIC_PORT_RST;
			st_next.ssc_rd = SEIC_SSC_RST;
		end

		// Registered pin outputs; held as they stand during halt [R17]
		if (st_reg.state != SEIC_ST_HALT)
		begin
			st_next.sync_clk = seic_sync_sel(st_next.fsel, st_next.latch, cyc.phase);
			st_next.so = seic_so_sel(st_next.fsel, st_next.ssc);
			st_next.drive = st_next.fsel[SEIC_FS_PORT]; // [R10]
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg <= '0;
			st_reg.state <= SEIC_ST_INIT;
			st_reg.fsel <= SEIC_FSEL_RST;
			st_reg.ssc <= SEIC_SSC_RST;
			st_reg.latch <= SEIC_LATCH_RST;
			st_reg.port_latch <= SEIC_PORT_RST;
			st_reg.si_s <= 2'h3;
			st_reg.si_prev <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign ssc_rd_data = st_reg.ssc_rd;
	assign port_rd_data = st_reg.port_rd;
	assign init_active = (st_reg.state == SEIC_ST_INIT); // [R15]
	assign halted = (st_reg.state == SEIC_ST_HALT);
	assign sync_clock_out = st_reg.sync_clk;
	assign serial_out_pin = st_reg.so;
	assign port_out = st_reg.port_latch; // [R1]
	assign port_oe = {8{st_reg.drive}}; // [R10]
endmodule

/* File: seic_sva.sv */
// Checker for the serial I/O enable control block, bound to its top ports
`timescale 1ns/1ps
module seic_sva
	import seic_pkg::*;
(
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 resetn,
	// Instruction port
	input wire logic                 cmd_valid,
	input wire seic_pkg::seic_cmd_e  cmd,
	input wire logic [3:0]           cmd_acc,
	input wire logic [3:0]           cmd_mem,
	input wire logic                 cmd_ready,
	// Status and pins
	input wire logic                 init_active,
	input wire logic                 halted,
	input wire logic                 osc_out_pin,
	input wire logic                 serial_out_pin,
	input wire logic [7:0]           port_out,
	input wire logic [7:0]           port_oe
);
	logic tk;
	assign tk = cmd_valid && cmd_ready;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	a_camq_load: assert property (tk && cmd == SEIC_CMD_CAMQ
		|=> port_out == {$past(cmd_acc), $past(cmd_mem)}) else $error("port latch load wrong");
	a_fsel_drive: assert property (tk && cmd == SEIC_CMD_LOAD_FSEL
		|=> port_oe == {8{$past(cmd_acc[2])}}) else $error("drive enable wrong");
	a_halt_entry: assert property (tk && cmd == SEIC_CMD_HALT
		|=> halted && !cmd_ready) else $error("halt not entered");
	a_halt_osc: assert property (halted && $past(halted) |-> osc_out_pin)
		else $error("oscillator output not high in halt");
	a_halt_frozen: assert property (halted && $past(halted, 2)
		|-> $stable(port_out) && $stable(serial_out_pin)) else $error("state moved in halt");
	a_halt_wake: assert property (halted |=> halted || init_active)
		else $error("left halt without reset");
	a_init_clear: assert property (init_active ##1 init_active
		|-> port_oe == 8'h00 && port_out == 8'h00) else $error("init did not clear");
	a_ready_run: assert property (cmd_ready |-> !halted && !init_active)
		else $error("ready outside run");
	cover property (tk && cmd == SEIC_CMD_SWAP);
	cover property (halted ##1 halted);
	cover property (init_active ##1 !init_active);
endmodule
bind seic_top seic_sva i_sva (.clk, .resetn, .cmd_valid, .cmd, .cmd_acc, .cmd_mem, .cmd_ready,
	.init_active, .halted, .osc_out_pin, .serial_out_pin, .port_out, .port_oe);

/* File: seic_partner.sv */
// Far-side model: free-running oscillator source and serial input pulse source
`timescale 1ns/1ps
module seic_partner
(
	// Pins toward the block
	output logic osc_in_pin,
	output logic serial_in_pin
);
	localparam int CYC_NS = 2560;
	initial
	begin
		osc_in_pin = 1'b0;
		serial_in_pin = 1'b1;
		forever #160 osc_in_pin = ~osc_in_pin;
	end
	// Both halves two instruction cycles long, narrower pulses may be lost
	task automatic pulse(input int n);
		repeat (n)
		begin
			serial_in_pin = 1'b0;
			#(2 * CYC_NS);
			serial_in_pin = 1'b1;
			#(2 * CYC_NS);
		end
	endtask
endmodule

/* File: seic_top_test.sv */
// Self-checking bench for the serial I/O enable control block
`timescale 1ns/1ps
module seic_top_test;
	import seic_pkg::*;
	logic       clk, osc_in_pin, serial_in_pin, osc_out_pin, cmd_ready, init_active;
	logic       halted, sync_clock_out, serial_out_pin, osc_out_oe, osc_in_o, osc_in_oe;
	logic       rc_opt = 1'b0;
	logic [7:0] cmd_rom = 8'h96;
	logic       resetn = 1'b0, init_pin_n = 1'b1, cmd_valid = 1'b0, cmd_carry = 1'b0;
	logic [3:0] cmd_acc = 4'h0, cmd_mem = 4'h0, ssc_rd_data;
	logic [7:0] port_in = 8'h3c, port_rd_data, port_out, port_oe;
	seic_cmd_e  cmd = SEIC_CMD_NOP;
	int         n_mismatch = 0, tests_run = 0, k;
	// Row fields: select value, expected drive enables, expected serial out
	logic [12:0] rows [6] = '{13'h0000, 13'h0200, 13'h1201, 13'h09fe, 13'h0400, 13'h0dfe};

	seic_partner i_part (.osc_in_pin, .serial_in_pin);
	seic_top i_dut (.clk, .resetn, .init_pin_n, .osc_in_pin, .rc_option_pin(rc_opt),
		.osc_out_pin, .osc_out_oe, .osc_in_o, .osc_in_oe, .cmd_valid, .cmd, .cmd_acc,
		.cmd_mem, .cmd_carry, .cmd_rom, .cmd_ready, .ssc_rd_data, .port_rd_data,
		.init_active, .halted, .serial_in_pin, .sync_clock_out, .serial_out_pin, .port_in,
		.port_out, .port_oe);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until the edge where ready is seen high
	task automatic op(input seic_cmd_e c, input logic [3:0] a, input logic cy);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_acc <= a;
		cmd_mem <= 4'h5;
		cmd_carry <= cy;
		do @(negedge clk); while (cmd_ready !== 1'b1);
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask

	task automatic sk_count(output int n);
		n = 0;
		repeat (64)
		begin
			@(negedge clk);
			n += sync_clock_out;
		end
	endtask

	task automatic print_verdict();
		$display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		repeat (5) @(posedge clk);
		chk(port_oe, 8'h00);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			op(SEIC_CMD_LOAD_FSEL, rows[i][12:9], 1'b0);
			repeat (3) @(negedge clk);
			chk(port_oe, rows[i][8:1]);
			chk(8'(serial_out_pin), 8'(rows[i][0]));
		end
		op(SEIC_CMD_CAMQ, 4'ha, 1'b0);
		repeat (5) @(negedge clk);
		chk(port_out, 8'ha5);
		chk(port_rd_data, 8'h3c);
		op(SEIC_CMD_LOAD_FSEL, 4'h8, 1'b0);
		op(SEIC_CMD_SWAP, 4'h0, 1'b1);
		repeat (400) @(negedge clk);
		chk(8'(serial_out_pin), 8'h01);
		sk_count(k);
		chk(8'(k), 8'h20);
		op(SEIC_CMD_SWAP, 4'h0, 1'b0);
		repeat (2) @(negedge clk);
		chk(8'(ssc_rd_data), 8'h0f);
		sk_count(k);
		chk(8'(k), 8'h00);
		op(SEIC_CMD_LOAD_FSEL, 4'h1, 1'b0);
		op(SEIC_CMD_SWAP, 4'h0, 1'b1);
		i_part.pulse(3);
		chk(8'(sync_clock_out), 8'h01);
		op(SEIC_CMD_SWAP, 4'h0, 1'b1);
		repeat (2) @(negedge clk);
		chk(8'(ssc_rd_data), 8'h0d);
		op(SEIC_CMD_HALT, 4'h0, 1'b0);
		repeat (100) @(negedge clk);
		chk(8'({halted, osc_out_pin, cmd_ready}), 8'h06);
		@(posedge clk);
		init_pin_n <= 1'b0;
		repeat (256) @(posedge clk);
		init_pin_n <= 1'b1;
		chk(8'({init_active, halted}), 8'h02);
		repeat (10) @(negedge clk);
		chk(8'({init_active, halted, cmd_ready}), 8'h01);
		chk(port_oe, 8'h00);
		op(SEIC_CMD_LQID, 4'h0, 1'b0);
		repeat (2) @(negedge clk);
		chk(port_out, 8'h96);
		@(posedge clk);
		rc_opt <= 1'b1;
		repeat (10) @(negedge clk);
		chk(8'({osc_out_oe, osc_in_oe}), 8'h00);
		op(SEIC_CMD_HALT, 4'h0, 1'b0);
		repeat (5) @(negedge clk);
		chk(8'({osc_in_oe, osc_in_o, osc_out_pin}), 8'h07);
		print_verdict();
	end
endmodule
